// ==== rtl/charger_irq_flag_mask_bank.sv ====
// Third event flag register, six interrupt mask registers and the host interrupt.
//
// Operation
// R1: Flag 0x55 bit7 boost overload, clear-on-read.
// R2: Bit6 latches boost mid-rail overvoltage until read.
// R3: Bit5 latches boost low input fault.
// R4: Bit1 latches pulse signalling done event.
// R5: Bit0 latches measurement done event.
// R6: Mask bit 0 passes, 1 blocks.
// R7: Status mask at 0x60, reset 0xF0.
// R8: Fault mask at 0x61, reset 0xF0.
// R9: Temperature mask at 0x62, reset 0xFF.
// R10: First event mask at 0x63, reset 0xFF.
// R11: Bits 2..0 gate status/fault/temperature changes.
// R12: Second event mask at 0x64, reset 0xFF.
// R13: Bits 1,0 gate measurement events; bit2 reserved.
// R14: Third event mask at 0x65, reset 0xFF.
// R15: Bits 1,0 gate pulse and measurement done.
// R16: Any status bit change pulses status-change event.
// R17: Status bit6 is 1 while voltage loop active.
// R18: Interrupt while any unmasked flag stays pending.
// R19: Host reads flags after interrupt, unmasks wanted.
`timescale 1ns/1ps
module charger_irq_flag_mask_bank (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata_r,
    input  wire logic       power_good,
    input  wire logic       input_voltage_regulation,
    input  wire logic       input_current_loop,
    input  wire logic       thermal_regulation_loop,
    input  wire logic       input_overvoltage,
    input  wire logic       battery_overvoltage,
    input  wire logic       system_overvoltage,
    input  wire logic       system_undervoltage,
    input  wire logic       battery_hot,
    input  wire logic       battery_warm,
    input  wire logic       battery_cool,
    input  wire logic       battery_cold,
    input  wire logic       boost_overload,
    input  wire logic       boost_midrail_voltage_high,
    input  wire logic       boost_low_input,
    input  wire logic       pulse_signalling_done,
    input  wire logic       measurement_done,
    input  wire logic [7:0] first_event_flags,
    input  wire logic [7:0] second_event_flags,
    output logic      [7:0] charger_status_register_r,
    output logic            status_change_r,
    output logic            fault_change_r,
    output logic            temperature_change_r,
    output logic            irq_n_r
);
    typedef struct packed {
        logic [7:0]  status_mask;
        logic [7:0]  fault_mask;
        logic [7:0]  temp_mask;
        logic [7:0]  event1_mask;
        logic [7:0]  event2_mask;
        logic [7:0]  event3_mask;
        logic [2:0]  third_rsvd;
        logic [11:0] level_s1;
        logic [11:0] level_s2;
        logic [11:0] level_prev;
        logic [4:0]  event_s1;
        logic [4:0]  event_s2;
        logic [4:0]  event_prev;
        logic [7:0]  rdata;
        logic [7:0]  charger_status;
        logic        status_change;
        logic        fault_change;
        logic        temp_change;
        logic        irq_n;
    } bank_state_t;

    localparam bank_state_t STATE_RESET = '{
        status_mask:    chg_irq_pkg::STATUS_MASK_RESET,
        fault_mask:     chg_irq_pkg::FAULT_MASK_RESET,
        temp_mask:      chg_irq_pkg::TEMP_MASK_RESET,
        event1_mask:    chg_irq_pkg::EVENT1_MASK_RESET,
        event2_mask:    chg_irq_pkg::EVENT2_MASK_RESET,
        event3_mask:    chg_irq_pkg::EVENT3_MASK_RESET,
        third_rsvd:     chg_irq_pkg::THIRD_FLAG_RESET[chg_irq_pkg::THIRD_RSVD_HI:
                                                      chg_irq_pkg::THIRD_RSVD_LO],
        level_s1:       12'h000,
        level_s2:       12'h000,
        level_prev:     12'h000,
        event_s1:       5'h00,
        event_s2:       5'h00,
        event_prev:     5'h00,
        rdata:          8'h00,
        charger_status: 8'h00,
        status_change:  1'b0,
        fault_change:   1'b0,
        temp_change:    1'b0,
        irq_n:          1'b1
    };

    logic [1:0]  rst_pipe_r;
    logic        rst_sync_n;
    bank_state_t state_r;
    bank_state_t state_nxt;

    logic [11:0] level_in;
    logic [4:0]  event_in;
    logic [11:0] level_diff;
    logic [4:0]  event_rise;
    logic [2:0]  change_hit_set;
    logic [2:0]  change_hits;
    logic [4:0]  third_flags;
    logic [7:0]  third_view;
    logic        third_read;
    logic        first_read;
    logic        access_wr;
    logic [4:0]  third_mask_bits;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_pipe_r <= 2'h0;
        end
        else
        begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe_r[1];

    // Level groups: status [11:8], fault [7:4], temperature [3:0].
    assign level_in = {power_good, input_voltage_regulation, input_current_loop,
                       thermal_regulation_loop, input_overvoltage, battery_overvoltage,
                       system_overvoltage, system_undervoltage, battery_hot,
                       battery_warm, battery_cool, battery_cold};
    assign event_in = {boost_overload, boost_midrail_voltage_high, boost_low_input,
                       pulse_signalling_done, measurement_done};

    // Only the second synchroniser stage feeds the detectors.
    assign level_diff = state_r.level_s2 ^ state_r.level_prev;
    assign event_rise = state_r.event_s2 & ~state_r.event_prev;

    // A change is kept for the interrupt only when its own source is unmasked. [R6]
    assign change_hit_set[2] = |(level_diff[11:8] & ~state_r.status_mask[7:4]);   // [R7]
    assign change_hit_set[1] = |(level_diff[7:4] & ~state_r.fault_mask[7:4]);     // [R8]
    assign change_hit_set[0] = |(level_diff[3:0] & ~state_r.temp_mask[7:4]);      // [R9]

    assign third_read = reg_rd && (reg_addr == chg_irq_pkg::THIRD_FLAG_ADDR);
    assign first_read = reg_rd && (reg_addr == chg_irq_pkg::FIRST_EVENT_ADDR);
    assign access_wr  = reg_wr && !reg_rd;

    // Events latch on the rising edge and clear when the host reads 0x55. [R1] [R2] [R3] [R4] [R5]
    sticky_flag_bank #(
        .WIDTH(5)
    ) third_event_bank (
        .clock    (clock),
        .rst_n    (rst_sync_n),
        .set_vec  (event_rise),
        .clear_all(third_read),
        .flags_r  (third_flags)
    );

    // Pending unmasked changes live until the first event register is read.
    sticky_flag_bank #(
        .WIDTH(3)
    ) change_hit_bank (
        .clock    (clock),
        .rst_n    (rst_sync_n),
        .set_vec  (change_hit_set),
        .clear_all(first_read),
        .flags_r  (change_hits)
    );

    always_comb
    begin
        third_view = 8'h00;
        third_view[chg_irq_pkg::BOOST_OVERLOAD_BIT]  = third_flags[4];
        third_view[chg_irq_pkg::BOOST_MIDRAIL_BIT]   = third_flags[3];
        third_view[chg_irq_pkg::BOOST_LOW_INPUT_BIT] = third_flags[2];
        third_view[chg_irq_pkg::THIRD_RSVD_HI:chg_irq_pkg::THIRD_RSVD_LO] = state_r.third_rsvd;
        third_view[chg_irq_pkg::PULSE_DONE_BIT]      = third_flags[1];
        third_view[chg_irq_pkg::MEAS_DONE_BIT]       = third_flags[0];
    end

    assign third_mask_bits = {state_r.event3_mask[chg_irq_pkg::BOOST_OVERLOAD_BIT],
                              state_r.event3_mask[chg_irq_pkg::BOOST_MIDRAIL_BIT],
                              state_r.event3_mask[chg_irq_pkg::BOOST_LOW_INPUT_BIT],
                              state_r.event3_mask[chg_irq_pkg::PULSE_DONE_BIT],
                              state_r.event3_mask[chg_irq_pkg::MEAS_DONE_BIT]};

    always_comb
    begin
        state_nxt = state_r;

        state_nxt.level_s1   = level_in;
        state_nxt.level_s2   = state_r.level_s1;
        state_nxt.level_prev = state_r.level_s2;
        state_nxt.event_s1   = event_in;
        state_nxt.event_s2   = state_r.event_s1;
        state_nxt.event_prev = state_r.event_s2;

        // Loop indications are shown as levels, reserved nibble zero. [R17]
        state_nxt.charger_status = {state_r.level_s2[11:8], 4'h0};

        // One-cycle change pulses towards the first event flag register. [R16]
        state_nxt.status_change = |level_diff[11:8];
        state_nxt.fault_change  = |level_diff[7:4];
        state_nxt.temp_change   = |level_diff[3:0];

        if (access_wr)
        begin
            case (reg_addr)
                chg_irq_pkg::THIRD_FLAG_ADDR:
                begin
                    // Flag bits ignore writes; only the reserved field stores.
                    state_nxt.third_rsvd =
                        reg_wdata[chg_irq_pkg::THIRD_RSVD_HI:chg_irq_pkg::THIRD_RSVD_LO];
                end
                chg_irq_pkg::STATUS_MASK_ADDR: state_nxt.status_mask = reg_wdata;  // [R7]
                chg_irq_pkg::FAULT_MASK_ADDR:  state_nxt.fault_mask  = reg_wdata;  // [R8]
                chg_irq_pkg::TEMP_MASK_ADDR:   state_nxt.temp_mask   = reg_wdata;  // [R9]
                chg_irq_pkg::EVENT1_MASK_ADDR: state_nxt.event1_mask = reg_wdata;  // [R10]
                chg_irq_pkg::EVENT2_MASK_ADDR: state_nxt.event2_mask = reg_wdata;  // [R12]
                chg_irq_pkg::EVENT3_MASK_ADDR: state_nxt.event3_mask = reg_wdata;  // [R14]
                default:
                begin
                    state_nxt.third_rsvd = state_r.third_rsvd;
                end
            endcase
        end

        if (reg_rd)
        begin
            case (reg_addr)
                chg_irq_pkg::STATUS_ADDR:      state_nxt.rdata = state_r.charger_status;
                chg_irq_pkg::THIRD_FLAG_ADDR:  state_nxt.rdata = third_view;  // [R1]
                chg_irq_pkg::STATUS_MASK_ADDR: state_nxt.rdata = state_r.status_mask;
                chg_irq_pkg::FAULT_MASK_ADDR:  state_nxt.rdata = state_r.fault_mask;
                chg_irq_pkg::TEMP_MASK_ADDR:   state_nxt.rdata = state_r.temp_mask;
                chg_irq_pkg::EVENT1_MASK_ADDR: state_nxt.rdata = state_r.event1_mask;
                chg_irq_pkg::EVENT2_MASK_ADDR: state_nxt.rdata = state_r.event2_mask;
                chg_irq_pkg::EVENT3_MASK_ADDR: state_nxt.rdata = state_r.event3_mask;
                default:                       state_nxt.rdata = chg_irq_pkg::UNMAPPED_READ;
            endcase
        end

        // Every source is gated the same way: a 0 mask bit lets it through. [R6] [R18]
        state_nxt.irq_n = !(
              (|(third_flags & ~third_mask_bits))                                   // [R14] [R15]
            | (|(first_event_flags[7:chg_irq_pkg::EVENT1_SOURCE_LO]
                 & ~state_r.event1_mask[7:chg_irq_pkg::EVENT1_SOURCE_LO]))          // [R10]
            | (|(change_hits & ~state_r.event1_mask[2:0]))                          // [R11]
            | (|(second_event_flags & ~state_r.event2_mask
                 & chg_irq_pkg::EVENT2_USED)));                                     // [R12] [R13]
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_r <= STATE_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata_r               = state_r.rdata;
    assign charger_status_register_r = state_r.charger_status;
    assign status_change_r           = state_r.status_change;
    assign fault_change_r            = state_r.fault_change;
    assign temperature_change_r      = state_r.temp_change;
    assign irq_n_r                   = state_r.irq_n;
endmodule

// ==== rtl/chg_irq_pkg.sv ====
// Constants for the charger event flag and interrupt mask bank.
package chg_irq_pkg;
    localparam logic [7:0] STATUS_ADDR       = 8'h50;
    localparam logic [7:0] FIRST_EVENT_ADDR  = 8'h53;
    localparam logic [7:0] THIRD_FLAG_ADDR   = 8'h55;
    localparam logic [7:0] STATUS_MASK_ADDR  = 8'h60;
    localparam logic [7:0] FAULT_MASK_ADDR   = 8'h61;
    localparam logic [7:0] TEMP_MASK_ADDR    = 8'h62;
    localparam logic [7:0] EVENT1_MASK_ADDR  = 8'h63;
    localparam logic [7:0] EVENT2_MASK_ADDR  = 8'h64;
    localparam logic [7:0] EVENT3_MASK_ADDR  = 8'h65;

    localparam logic [7:0] THIRD_FLAG_RESET  = 8'h00;
    localparam logic [7:0] STATUS_MASK_RESET = 8'hF0;
    localparam logic [7:0] FAULT_MASK_RESET  = 8'hF0;
    localparam logic [7:0] TEMP_MASK_RESET   = 8'hFF;
    localparam logic [7:0] EVENT1_MASK_RESET = 8'hFF;
    localparam logic [7:0] EVENT2_MASK_RESET = 8'hFF;
    localparam logic [7:0] EVENT3_MASK_RESET = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;

    // Bit positions in the third event flag and mask registers.
    localparam int BOOST_OVERLOAD_BIT   = 7;
    localparam int BOOST_MIDRAIL_BIT    = 6;
    localparam int BOOST_LOW_INPUT_BIT  = 5;
    localparam int THIRD_RSVD_HI        = 4;
    localparam int THIRD_RSVD_LO        = 2;
    localparam int PULSE_DONE_BIT       = 1;
    localparam int MEAS_DONE_BIT        = 0;

    // Status, fault and temperature sources sit in bits 7 to 4.
    localparam int SOURCE_HI            = 7;
    localparam int SOURCE_LO            = 4;

    // Change-detected mask bits and lowest source bit of the first event mask register.
    localparam int STATUS_CHANGE_BIT    = 2;
    localparam int FAULT_CHANGE_BIT     = 1;
    localparam int TEMP_CHANGE_BIT      = 0;
    localparam int EVENT1_SOURCE_LO     = 3;

    // The reserved bit 2 of the second event mask never gates a source.
    localparam logic [7:0] EVENT2_USED  = 8'hFB;
endpackage

// ==== rtl/sticky_flag_bank.sv ====
// Bank of sticky flags where a set in the clearing cycle wins.
`timescale 1ns/1ps
module sticky_flag_bank #(
    parameter int WIDTH = 5
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic             clear_all,
    output logic      [WIDTH-1:0] flags_r
);
    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } bank_state_t;

    bank_state_t state_r;
    bank_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        if (clear_all)
        begin
            state_nxt.flags = '0;
        end
        // The set term comes last so an event in the read cycle survives.
        state_nxt.flags = state_nxt.flags | set_vec;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign flags_r = state_r.flags;
endmodule

// ==== verif/charger_irq_flag_mask_bank_tb_top.sv ====
// Self-checking bench for the charger event flag and mask bank.
`timescale 1ns/1ps
module charger_irq_flag_mask_bank_tb_top;
    logic       clock;
    logic       rst_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, fe, se, stat, dummy;
    logic       reg_wr, reg_rd, irq_n_r;
    logic [3:0] st, ft, tp;
    logic [4:0] ev;
    int         fails, checks_done, cyc, pulses;
    always #20 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        pulses += int'(uut.status_change_r);
        if (cyc == 20000)
        begin
            $display("[FAIL] %0t timeout", $time);
            fails++;
            end_of_test();
        end
    end
    chg_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
    charger_irq_flag_mask_bank uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .power_good(st[3]), .input_voltage_regulation(st[2]), .input_current_loop(st[1]),
        .thermal_regulation_loop(st[0]), .input_overvoltage(ft[3]), .battery_overvoltage(ft[2]),
        .system_overvoltage(ft[1]), .system_undervoltage(ft[0]), .battery_hot(tp[3]),
        .battery_warm(tp[2]), .battery_cool(tp[1]), .battery_cold(tp[0]),
        .boost_overload(ev[4]), .boost_midrail_voltage_high(ev[3]), .boost_low_input(ev[2]),
        .pulse_signalling_done(ev[1]), .measurement_done(ev[0]), .first_event_flags(fe),
        .second_event_flags(se), .charger_status_register_r(stat), .status_change_r(),
        .fault_change_r(), .temperature_change_r(), .irq_n_r(irq_n_r));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk8(d, exp);
    endtask
    task automatic wait_irq(input int n, input logic exp);
        repeat (n) @(negedge clock);
        chk8({7'h00, irq_n_r}, {7'h00, exp});
    endtask
    task automatic pulse(input int i);
        @(negedge clock);
        ev[i] = 1'b1;
        @(negedge clock);
        ev[i] = 1'b0;
    endtask
    task automatic t_reset;
        rdchk(8'h55, 8'h00);
        rdchk(8'h60, 8'hF0);
        rdchk(8'h61, 8'hF0);
        rdchk(8'h62, 8'hFF);
        rdchk(8'h63, 8'hFF);
        rdchk(8'h64, 8'hFF);
        rdchk(8'h65, 8'hFF);
        $display("reset values done");
    endtask
    task automatic t_masks;
        for (int a = 'h60; a <= 'h65; a++)
        begin
            host.wr(8'(a), 8'hA5);
            rdchk(8'(a), 8'hA5);
            host.wr(8'(a), 8'hFF);
        end
        host.wr(8'h55, 8'hFF);
        rdchk(8'h55, 8'h1C);
        host.wr(8'h55, 8'h00);
        rdchk(8'h70, chg_irq_pkg::UNMAPPED_READ);
        $display("mask access done");
    endtask
    task automatic t_events;
        logic [7:0] b;
        for (int i = 0; i < 5; i++)
        begin
            b = (i > 1) ? 8'h01 << (i + 3) : 8'h01 << i;
            pulse(i);
            wait_irq(7, 1'b1);
            rdchk(8'h55, b);
            rdchk(8'h55, 8'h00);
            host.wr(8'h65, ~b);
            pulse(i);
            wait_irq(7, 1'b0);
            rdchk(8'h55, b);
            wait_irq(2, 1'b1);
            host.wr(8'h65, 8'hFF);
        end
        $display("event flags done");
    endtask
    task automatic t_status;
        host.wr(8'h60, 8'hBF);
        host.wr(8'h63, 8'hF9);
        pulses = 0;
        st[2] = 1'b1;
        repeat (8) @(negedge clock);
        chk8(8'(pulses), 8'h01);
        rdchk(8'h50, 8'h40);
        wait_irq(0, 1'b0);
        host.rd(8'h53, dummy);
        ft[3] = 1'b1;
        wait_irq(9, 1'b1);
        host.wr(8'h62, 8'h7F);
        host.wr(8'h63, 8'hFE);
        tp[3] = 1'b1;
        wait_irq(9, 1'b0);
        host.wr(8'h63, 8'hFF);
        host.rd(8'h53, dummy);
        wait_irq(2, 1'b1);
        $display("status changes done");
    endtask
    task automatic t_levels;
        fe = 8'h08;
        wait_irq(3, 1'b1);
        host.wr(8'h63, 8'hF7);
        wait_irq(2, 1'b0);
        fe = 8'h00;
        host.wr(8'h63, 8'hFF);
        host.wr(8'h64, 8'h00);
        se = 8'h04;
        wait_irq(3, 1'b1);
        se = 8'h80;
        wait_irq(3, 1'b0);
        se = 8'h00;
        wait_irq(3, 1'b1);
        host.wr(8'h64, 8'hFF);
        se = 8'h03;
        wait_irq(3, 1'b1);
        host.wr(8'h64, 8'hFE);
        wait_irq(2, 1'b0);
        se = 8'h00;
        wait_irq(3, 1'b1);
        $display("level events done");
    endtask
    // Reset in mid-run must bring every mask back although the levels stay high.
    task automatic t_midrst;
        @(negedge clock);
        rst_n = 1'b0;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        wait_irq(0, 1'b1);
        t_reset();
        rdchk(8'h50, 8'h40);
        $display("mid-run reset done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        {clock, rst_n, st, ft, tp, ev, fe, se} = '0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_reset();
        t_masks();
        t_events();
        t_status();
        t_levels();
        t_midrst();
        end_of_test();
    end
endmodule

// ==== verif/chg_host.sv ====
// Host processor model that reaches the bank through its register port.
`timescale 1ns/1ps
module chg_host (
    input  wire logic       clock,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata_r
);
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h00000;
    // Each strobe covers exactly one rising edge, so one access is taken per call.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    // The registered read data is taken one edge after the strobe, where it has settled.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d = reg_rdata_r;
    endtask
endmodule

// ==== verif/chg_irq_sva.sv ====
// Port-level checks for the charger event flag and mask bank.
`timescale 1ns/1ps
module chg_irq_sva (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       input_voltage_regulation,
    input wire logic       input_overvoltage,
    input wire logic       battery_hot,
    input wire logic [7:0] first_event_flags,
    input wire logic [7:0] second_event_flags,
    input wire logic [7:0] charger_status_register_r,
    input wire logic       status_change_r,
    input wire logic       fault_change_r,
    input wire logic       temperature_change_r,
    input wire logic       irq_n_r
);
    logic [7:0] mask_r [6];
    logic [7:0] rd_exp_r;
    logic       rd_chk_r;
    logic [4:0] up_r;
    logic       settled;
    logic       in_map;
    // Loop-bit, change and interrupt checks wait for the synchronisers to fill after each reset release.
    assign settled = (up_r == 5'h1F);
    assign in_map = (reg_addr >= 8'h60) && (reg_addr <= 8'h65);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_r <= '{8'hF0, 8'hF0, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
            rd_chk_r <= 1'b0;
            rd_exp_r <= 8'h00;
            up_r <= 5'h00;
        end
        else
        begin
            up_r <= settled ? up_r : up_r + 5'h01;
            rd_chk_r <= reg_rd && in_map;
            if (in_map)
                rd_exp_r <= mask_r[reg_addr[2:0]];
            if (reg_wr && !reg_rd && in_map)
                mask_r[reg_addr[2:0]] <= reg_wdata;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_mask_readback:
        assert property (rd_chk_r |-> reg_rdata_r == rd_exp_r) else $error("Mask readback.");
    chk_status_nibble:
        assert property (charger_status_register_r[3:0] == 4'h0) else $error("Status nibble.");
    chk_voltage_loop_bit:
        assert property ((settled && $stable(input_voltage_regulation)) [*5]
            |-> charger_status_register_r[6] == input_voltage_regulation) else $error("Loop bit.");
    chk_status_change:
        assert property (settled && $changed(charger_status_register_r) |-> ##[0:2] status_change_r)
            else $error("Status change pulse.");
    chk_fault_change:
        assert property (settled && $changed(input_overvoltage) |-> ##[2:6] fault_change_r)
            else $error("Fault change pulse.");
    chk_temp_change:
        assert property (settled && $changed(battery_hot) |-> ##[2:6] temperature_change_r)
            else $error("Temperature change pulse.");
    chk_first_unmasked:
        assert property ((settled && (first_event_flags[7:3] & ~mask_r[3][7:3]) != 5'h00) [*2]
            |-> !irq_n_r) else $error("First event irq.");
    chk_second_unmasked:
        assert property ((settled && (second_event_flags & ~mask_r[4] & 8'hFB) != 8'h00) [*2]
            |-> !irq_n_r) else $error("Second event irq.");
    chk_all_masked_quiet:
        assert property ((settled && (mask_r[3] & mask_r[4] & mask_r[5]) == 8'hFF) [*2]
            |-> irq_n_r) else $error("Masked irq.");
    cover property (!irq_n_r);
    cover property (status_change_r);
    cover property (rd_chk_r);
endmodule
bind charger_irq_flag_mask_bank chg_irq_sva sva_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .input_voltage_regulation(input_voltage_regulation), .input_overvoltage(input_overvoltage),
    .battery_hot(battery_hot), .first_event_flags(first_event_flags),
    .second_event_flags(second_event_flags), .charger_status_register_r(charger_status_register_r),
    .status_change_r(status_change_r), .fault_change_r(fault_change_r),
    .temperature_change_r(temperature_change_r), .irq_n_r(irq_n_r)
);
